// ---- ufhic_pkg.sv ----
// Purpose: Shared constants and types for the UART holding, queue and interrupt control block.
// Assumes: One 16x baud clock drives the whole block.
// Notes: Register addresses follow the three-bit register select of the parallel bus.
package ufhic_pkg;

  // ==========================================================================
  // Register addresses and bus
  // ==========================================================================
  localparam logic [2:0] UFHIC_ADDR_HOLDING = 3'h0;
  localparam logic [2:0] UFHIC_ADDR_MASK = 3'h1;
  localparam logic [2:0] UFHIC_ADDR_QUEUE = 3'h2;
  localparam logic [2:0] UFHIC_ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] UFHIC_ADDR_LINE_STATUS = 3'h5;
  localparam logic [7:0] UFHIC_MASK_RESET = 8'h00;
  localparam logic [7:0] UFHIC_LINE_CTRL_RESET = 8'h03;
  localparam int UFHIC_DLAB_BIT = 7;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int UFHIC_IE_RX = 0;
  localparam int UFHIC_IE_TX = 1;
  localparam int UFHIC_IE_LS = 2;
  localparam int UFHIC_IE_MS = 3;
  localparam int UFHIC_QC_EN = 0;
  localparam int UFHIC_QC_RXCLR = 1;
  localparam int UFHIC_QC_TXCLR = 2;
  localparam int UFHIC_QC_DMA = 3;
  localparam int UFHIC_QC_TRIG_LO = 6;
  localparam int UFHIC_QC_TRIG_HI = 7;

  // ==========================================================================
  // Queue and timing
  // ==========================================================================
  localparam int UFHIC_DEPTH = 16;
  localparam int UFHIC_PTR_W = 4;
  localparam int UFHIC_CNT_W = 5;
  localparam logic [3:0] UFHIC_OVERSAMPLE = 4'hF;   // Last tick of a 16-tick bit.
  localparam logic [3:0] UFHIC_START_MID = 4'h7;    // Centre of start bit.
  localparam int UFHIC_CHAR_BITS = 10;
  localparam int UFHIC_TIMEOUT_CHARS = 4;
  localparam int UFHIC_TIMEOUT_TICKS = UFHIC_TIMEOUT_CHARS * UFHIC_CHAR_BITS * 16;
  localparam logic [9:0] UFHIC_TIMEOUT_CNT = 10'(UFHIC_TIMEOUT_TICKS);

  // Interrupt identification codes.
  localparam logic [3:0] UFHIC_ID_NONE = 4'h1;
  localparam logic [3:0] UFHIC_ID_LINE = 4'h6;
  localparam logic [3:0] UFHIC_ID_RXDATA = 4'h4;
  localparam logic [3:0] UFHIC_ID_TIMEOUT = 4'hC;
  localparam logic [3:0] UFHIC_ID_TXEMPTY = 4'h2;
  localparam logic [3:0] UFHIC_ID_MODEM = 4'h0;

  // Received word: data plus per-character error flags.
  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic [7:0] data;
  } ufhic_rx_word_type;

  // Host bus request bundle.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ufhic_bus_type;

  typedef enum logic [1:0] {UFHIC_RX_IDLE, UFHIC_RX_START, UFHIC_RX_DATA, UFHIC_RX_STOP}
    ufhic_rx_state_type;

endpackage : ufhic_pkg

// ---- ufhic_queue.sv ----
// Purpose: Sixteen-entry first-in first-out store with occupancy count.
// Assumes: Push on full and pop on empty need no filtering by the caller; the store ignores them itself.
// Notes: Flush empties the store and resets pointers in one cycle.
`timescale 1ns/1ps
module ufhic_queue import ufhic_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  // Status
  output logic [WIDTH-1:0] head_data,
  output logic [UFHIC_CNT_W-1:0] count
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [WIDTH-1:0] mem_q [UFHIC_DEPTH];
  logic [UFHIC_PTR_W-1:0] wr_ptr_q;
  logic [UFHIC_PTR_W-1:0] rd_ptr_q;
  logic [UFHIC_CNT_W-1:0] count_q;
  wire do_push = push && (count_q != UFHIC_CNT_W'(UFHIC_DEPTH));
  wire do_pop = pop && (count_q != '0);

  assign head_data = mem_q[rd_ptr_q];
  assign count = count_q;

  // Data array has no reset; only pointers define contents.
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  // Pointers and count; flush wins over traffic.
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + UFHIC_PTR_W'(do_push);
      rd_ptr_q <= rd_ptr_q + UFHIC_PTR_W'(do_pop);
      count_q <= count_q + UFHIC_CNT_W'(do_push) - UFHIC_CNT_W'(do_pop);
    end
  end

endmodule : ufhic_queue

// ---- ufhic_core.sv ----
// Purpose: Holding registers, shifters, queues, interrupt gating and DMA ready pins of a UART.
// Assumes: All inputs synchronous to clk, which is the 16x baud clock; 8N1 framing.
// Notes: Line, modem and divisor logic outside; line control kept only for its latch bit.
`timescale 1ns/1ps
module ufhic_core import ufhic_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Parallel register bus
  input wire logic [2:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Serial line and modem status event
  input wire logic serial_in,
  input wire logic modem_event,
  output logic serial_out,
  // Interrupt and DMA pins
  output logic irq,
  output logic transmit_ready_pin_n,
  output logic receive_ready_pin_n
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  ufhic_bus_type bus;
  assign bus = '{rd: bus_rd, wr: bus_wr, addr: bus_addr, wdata: bus_wdata};

  logic [7:0] mask_q;
  logic [7:0] line_ctrl_q;
  logic fifo_en_q;
  logic dma_mode_q;
  logic [1:0] trig_sel_q;

  // Registers below the divisor-latch bit are the normal set only.
  // Latch bit gating
  wire normal_set = !line_ctrl_q[UFHIC_DLAB_BIT];
  wire wr_holding = bus.wr && normal_set && (bus.addr == UFHIC_ADDR_HOLDING);
  wire wr_mask = bus.wr && normal_set && (bus.addr == UFHIC_ADDR_MASK);
  wire wr_queue = bus.wr && (bus.addr == UFHIC_ADDR_QUEUE);
  wire wr_line_ctrl = bus.wr && (bus.addr == UFHIC_ADDR_LINE_CTRL);
  wire rd_holding = bus.rd && normal_set && (bus.addr == UFHIC_ADDR_HOLDING);
  wire rd_ident = bus.rd && (bus.addr == UFHIC_ADDR_QUEUE);
  wire rd_status = bus.rd && (bus.addr == UFHIC_ADDR_LINE_STATUS);
  wire queue_take = wr_queue && bus.wdata[UFHIC_QC_EN];
  wire tx_flush = queue_take && bus.wdata[UFHIC_QC_TXCLR];
  wire rx_flush = queue_take && bus.wdata[UFHIC_QC_RXCLR];

  // Trigger level decode used by interrupt and ready pin logic.
  function automatic logic [UFHIC_CNT_W-1:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      default: trig_level = 5'h0E;
    endcase
  endfunction : trig_level

  // Control registers; a queue write with enable clear only clears the enable, per intent.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_q <= UFHIC_MASK_RESET;
      line_ctrl_q <= UFHIC_LINE_CTRL_RESET;
      fifo_en_q <= 1'b0;
      dma_mode_q <= 1'b0;
      trig_sel_q <= 2'h0;
    end else begin
      if (wr_mask) mask_q <= {4'h0, bus.wdata[3:0]};
      if (wr_line_ctrl) line_ctrl_q <= bus.wdata;
      if (wr_queue) fifo_en_q <= bus.wdata[UFHIC_QC_EN];
      if (queue_take) begin
        dma_mode_q <= bus.wdata[UFHIC_QC_DMA];
        trig_sel_q <= bus.wdata[UFHIC_QC_TRIG_HI:UFHIC_QC_TRIG_LO];
      end
    end
  end

  // ==========================================================================
  // Transmit path
  // ==========================================================================
  logic [7:0] tx_head;
  logic [UFHIC_CNT_W-1:0] tx_count;
  logic [9:0] tx_shift_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_tick_q;
  logic tx_busy_q;
  // Without queues only one holding slot exists.
  wire [UFHIC_CNT_W-1:0] tx_cap = fifo_en_q ? UFHIC_CNT_W'(UFHIC_DEPTH) : 5'h01;
  wire tx_push = wr_holding && (tx_count < tx_cap);
  wire tx_load = !tx_busy_q && (tx_count != '0);
  wire tx_bit_end = tx_busy_q && (tx_tick_q == UFHIC_OVERSAMPLE);

  ufhic_queue #(.WIDTH(8)) u_tx_queue (
    .clk(clk),
    .reset_n(reset_n),
    .flush(tx_flush),
    .push(tx_push),
    .push_data(bus.wdata),
    .pop(tx_load),
    .head_data(tx_head),
    .count(tx_count)
  );

  // Shifter sends start, eight data, stop; flush does not touch it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_shift_q <= '1;
      tx_bits_q <= '0;
      tx_tick_q <= '0;
      tx_busy_q <= 1'b0;
    end else if (tx_load) begin
      tx_shift_q <= {1'b1, tx_head, 1'b0};
      tx_bits_q <= 4'(UFHIC_CHAR_BITS - 1);
      tx_tick_q <= '0;
      tx_busy_q <= 1'b1;
    end else if (tx_busy_q) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_bit_end) begin
        tx_shift_q <= {1'b1, tx_shift_q[9:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        tx_busy_q <= (tx_bits_q != '0);
      end
    end
  end

  wire hold_empty = fifo_en_q ? (tx_count == '0) : (tx_count == '0);
  wire tx_all_empty = hold_empty && !tx_busy_q;
  wire tx_full = (tx_count == UFHIC_CNT_W'(UFHIC_DEPTH));

  // ==========================================================================
  // Receive path
  // ==========================================================================
  ufhic_rx_state_type rx_state_q;
  logic [3:0] rx_tick_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_data_q;
  logic rx_line_q;
  logic rx_push_q;
  ufhic_rx_word_type rx_word_q;
  ufhic_rx_word_type rx_head;
  logic [UFHIC_CNT_W-1:0] rx_count;
  logic overrun_q;
  logic [9:0] idle_cnt_q;
  logic timeout_q;
  wire rx_fall = rx_line_q && !serial_in;
  wire rx_mid = (rx_tick_q == UFHIC_START_MID);
  wire rx_end = (rx_tick_q == UFHIC_OVERSAMPLE);
  wire [UFHIC_CNT_W-1:0] rx_cap = fifo_en_q ? UFHIC_CNT_W'(UFHIC_DEPTH) : 5'h01;
  wire rx_pop = rd_holding;

  ufhic_queue #(.WIDTH($bits(ufhic_rx_word_type))) u_rx_queue (
    .clk(clk),
    .reset_n(reset_n),
    .flush(rx_flush),
    // Without queues the single holding slot refuses a second word; it counts as overrun.
    .push(rx_push_q && (rx_count < rx_cap)),
    .push_data(rx_word_q),
    .pop(rx_pop),
    .head_data(rx_head),
    .count(rx_count)
  );

  // Receiver state machine; the data shifter is unaffected by flush.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_state_q <= UFHIC_RX_IDLE;
      rx_tick_q <= '0;
      rx_bit_q <= '0;
      rx_data_q <= '0;
      rx_line_q <= 1'b1;
      rx_push_q <= 1'b0;
      rx_word_q <= '0;
    end else begin
      rx_line_q <= serial_in;
      rx_push_q <= 1'b0;
      rx_tick_q <= rx_tick_q + 4'h1;
      case (rx_state_q)
        UFHIC_RX_IDLE: begin
          rx_tick_q <= '0;
          if (rx_fall) rx_state_q <= UFHIC_RX_START;
        end
        UFHIC_RX_START: begin
          if (rx_mid) begin
            rx_tick_q <= '0;
            rx_bit_q <= '0;
            rx_state_q <= serial_in ? UFHIC_RX_IDLE : UFHIC_RX_DATA;
          end
        end
        UFHIC_RX_DATA: begin
          if (rx_end) begin
            rx_data_q <= {serial_in, rx_data_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) rx_state_q <= UFHIC_RX_STOP;
          end
        end
        UFHIC_RX_STOP: begin
          if (rx_end) begin
            rx_word_q <= '{brk: !serial_in && (rx_data_q == '0), framing: !serial_in,
                           parity: 1'b0, data: rx_data_q};
            rx_push_q <= 1'b1;
            rx_state_q <= UFHIC_RX_IDLE;
          end
        end
        default: rx_state_q <= UFHIC_RX_IDLE;
      endcase
    end
  end

  wire rx_overflow = rx_push_q && (rx_count >= rx_cap);
  wire [UFHIC_CNT_W-1:0] trig = fifo_en_q ? trig_level(trig_sel_q) : 5'h01;
  wire trig_hit = (rx_count >= trig);
  wire rx_any = (rx_count != '0);
  // A framing or break error among the queued words is tracked as a summary held until the queue empties.
  logic queued_err_q;

  // Overrun and queued-error flags; a new overrun wins over the status-read clear, a new error over the empty-queue clear.
  always_ff @(posedge clk) begin
    if (!reset_n || rx_flush) begin
      overrun_q <= 1'b0;
      queued_err_q <= 1'b0;
    end else begin
      overrun_q <= rx_overflow || (overrun_q && !rd_status);
      queued_err_q <= (rx_push_q && (rx_word_q.framing || rx_word_q.brk)) ||
                      (queued_err_q && rx_any);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || rx_push_q || rx_pop || !rx_any || trig_hit) begin
      idle_cnt_q <= '0;
      timeout_q <= 1'b0;
    end else if (idle_cnt_q == UFHIC_TIMEOUT_CNT) begin
      timeout_q <= fifo_en_q;
    end else begin
      idle_cnt_q <= idle_cnt_q + 10'h001;
    end
  end

  // ==========================================================================
  // Status, identification and interrupt
  // ==========================================================================
  // Line status composition
  wire [7:0] line_status = {queued_err_q, tx_all_empty, hold_empty,
                            rx_any && rx_head.brk, rx_any && rx_head.framing,
                            rx_any && rx_head.parity, overrun_q, rx_any};
  wire src_line = mask_q[UFHIC_IE_LS] && (overrun_q || line_status[4:2] != '0);
  wire src_rx = mask_q[UFHIC_IE_RX] && trig_hit;
  wire src_to = mask_q[UFHIC_IE_RX] && timeout_q;
  wire src_tx = mask_q[UFHIC_IE_TX] && hold_empty;
  wire src_ms = mask_q[UFHIC_IE_MS] && modem_event;
  wire any_src = src_line || src_rx || src_to || src_tx || src_ms;
  wire [3:0] ident = src_line ? UFHIC_ID_LINE : src_rx ? UFHIC_ID_RXDATA :
                     src_to ? UFHIC_ID_TIMEOUT : src_tx ? UFHIC_ID_TXEMPTY :
                     src_ms ? UFHIC_ID_MODEM : UFHIC_ID_NONE;
  wire [7:0] rdata_d = (bus.addr == UFHIC_ADDR_HOLDING && normal_set) ? rx_head.data :
                       (bus.addr == UFHIC_ADDR_MASK && normal_set) ? mask_q :
                       rd_ident ? {{2{fifo_en_q}}, 2'h0, ident} :
                       (bus.addr == UFHIC_ADDR_LINE_CTRL) ? line_ctrl_q :
                       (bus.addr == UFHIC_ADDR_LINE_STATUS) ? line_status : 8'h00;

  wire mode1 = fifo_en_q && dma_mode_q;
  wire transmit_ready_pin_d = mode1 ? (tx_full ? 1'b1 : (tx_count == '0) ? 1'b0 : transmit_ready_pin_n)
                       : !hold_empty;
  wire receive_ready_pin_d = mode1 ? ((trig_hit || timeout_q) ? 1'b0 : !rx_any ? 1'b1 : receive_ready_pin_n)
                       : !rx_any;

  // Registered outputs.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rdata <= 8'h00;
      irq <= 1'b0;
      transmit_ready_pin_n <= 1'b0;
      receive_ready_pin_n <= 1'b1;
      serial_out <= 1'b1;
    end else begin
      bus_rdata <= bus.rd ? rdata_d : 8'h00;
      irq <= any_src;
      transmit_ready_pin_n <= transmit_ready_pin_d;
      receive_ready_pin_n <= receive_ready_pin_d;
      serial_out <= tx_busy_q ? tx_shift_q[0] : 1'b1;
    end
  end

endmodule : ufhic_core

// ---- ufhic_asserts.sv ----
// Purpose: Port-level checks of the UART holding, queue and interrupt core.
// Assumes: Shadows of mask, queue control and latch bit follow host writes.
// Notes: Attached to every core instance by the bind at the foot.
`timescale 1ns/1ps
module ufhic_asserts import ufhic_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire logic [2:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  // Line, interrupt and ready pins
  input wire logic serial_in,
  input wire logic modem_event,
  input wire logic serial_out,
  input wire logic irq,
  input wire logic transmit_ready_pin_n,
  input wire logic receive_ready_pin_n
);
  // ==========================================================================
  // Register shadows
  // ==========================================================================
  logic [3:0] mask_q;
  logic dlab_q;
  logic qen_q;
  logic dma_q;
  // Main registers are reached only while the latch bit is clear.
  wire main_wr = bus_wr && !dlab_q;
  wire qc_wr = main_wr && bus_addr == UFHIC_ADDR_QUEUE;
  wire mode0 = !(qen_q && dma_q);
  // Shadows move on the same edge as the core, so reads compare like for like.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_q <= 4'h0;
      dlab_q <= 1'b0;
      qen_q <= 1'b0;
      dma_q <= 1'b0;
    end else begin
      if (bus_wr && bus_addr == UFHIC_ADDR_LINE_CTRL) dlab_q <= bus_wdata[UFHIC_DLAB_BIT];
      if (main_wr && bus_addr == UFHIC_ADDR_MASK) mask_q <= bus_wdata[3:0];
      if (qc_wr) qen_q <= bus_wdata[UFHIC_QC_EN];
      if (qc_wr && bus_wdata[UFHIC_QC_EN]) dma_q <= bus_wdata[UFHIC_QC_DMA];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  rst_vals_a: assert property (
    $rose(reset_n) |-> !irq && serial_out && !transmit_ready_pin_n && receive_ready_pin_n)
    else $error("Outputs not at their reset levels after release.");
  rdata_idle_a: assert property (
    !$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("Read data not zero outside a read answer.");
  mask_read_a: assert property (
    bus_rd && bus_addr == UFHIC_ADDR_MASK && !dlab_q |=> bus_rdata[3:0] == mask_q)
    else $error("Mask read differs from the value written.");
  ident_read_a: assert property (
    bus_rd && bus_addr == UFHIC_ADDR_QUEUE |=> bus_rdata[7:4] == {qen_q, qen_q, 2'b00})
    else $error("Identification high bits do not follow queue enable.");
  polled_quiet_a: assert property (
    mask_q == 4'h0 && $past(mask_q) == 4'h0 && $past(mask_q, 2) == 4'h0 |-> !irq)
    else $error("Interrupt raised with every source masked.");
  modem_gate_a: assert property (
    mask_q[3] && modem_event |-> ##[1:3] irq)
    else $error("Enabled modem event did not raise the interrupt.");
  transmit_ready_pin_load_a: assert property (
    main_wr && bus_addr == UFHIC_ADDR_HOLDING && mode0 |-> ##[1:3] transmit_ready_pin_n)
    else $error("Transmit ready pin did not rise after a load.");
  bit_width_a: assert property (
    $fell(serial_out) |-> !serial_out [*8] ##1 !serial_out [*8])
    else $error("Low serial bit shorter than sixteen ticks.");
endmodule : ufhic_asserts

bind ufhic_core ufhic_asserts u_asserts (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .serial_in(serial_in), .modem_event(modem_event), .serial_out(serial_out), .irq(irq),
  .transmit_ready_pin_n(transmit_ready_pin_n), .receive_ready_pin_n(receive_ready_pin_n));

// ---- ufhic_host_model.sv ----
// Purpose: Host bus master and remote serial sender facing the core.
// Assumes: Requests launch on the falling edge and are taken on the next rise.
// Notes: Released bus fields carry inverted values so stale data never matches.
`timescale 1ns/1ps
module ufhic_host_model import ufhic_pkg::*; (
  // Clock
  input wire logic clk,
  // Register bus
  output ufhic_bus_type bus_req,
  input wire logic [7:0] bus_rdata,
  // Serial line into the core
  output logic serial_in
);
  // ==========================================================================
  // Bus and line tasks
  // ==========================================================================
  // Idle line rests at the mark level.
  initial begin
    bus_req = '{1'b0, 1'b0, 3'h7, 8'hFF};
    serial_in = 1'b1;
  end

  // One-cycle write strobe, then release with inverted fields.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_req <= '{1'b0, 1'b1, a, d};
    @(negedge clk);
    bus_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // Read data is registered at the taking edge and picked up half a cycle later.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_req <= '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    d = bus_rdata;
    bus_req <= '{1'b0, 1'b0, ~a, 8'hFF};
  endtask : rd

  task automatic init;
    wr(UFHIC_ADDR_LINE_CTRL, UFHIC_LINE_CTRL_RESET);
  endtask : init

  // Eight bits LSB first; a bad stop bit is cut short so it cannot pass as a start.
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] fr;
    fr = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_in <= fr[i];
      repeat (i == 9 ? 10 : 16) @(negedge clk);
    end
    serial_in <= 1'b1;
    repeat (6) @(negedge clk);
  endtask : send

  task automatic glitch(input int n);
    serial_in <= 1'b0;
    repeat (n) @(negedge clk);
    serial_in <= 1'b1;
  endtask : glitch
endmodule : ufhic_host_model

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the UART holding, queue and interrupt core.
// Assumes: 40 MHz clock used directly as the 16x tick.
// Notes: Each scenario task drives the core and judges the answers itself.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top import ufhic_pkg::*; ;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic modem_event = 1'b0;
  ufhic_bus_type bus_req;
  logic [7:0] bus_rdata;
  logic serial_in, serial_out, irq, tx_rdy_n, rx_rdy_n;
  int miscompares = 0;
  int n_checks = 0;

  // ==========================================================================
  // Instances and clock
  // ==========================================================================
  ufhic_host_model host (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .serial_in(serial_in));
  ufhic_core uut (.clk(clk), .reset_n(reset_n), .bus_addr(bus_req.addr), .bus_wr(bus_req.wr),
    .bus_rd(bus_req.rd), .bus_wdata(bus_req.wdata), .bus_rdata(bus_rdata),
    .serial_in(serial_in), .modem_event(modem_event), .serial_out(serial_out), .irq(irq),
    .transmit_ready_pin_n(tx_rdy_n), .receive_ready_pin_n(rx_rdy_n));
  // Free-running tick clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    host.rd(a, v);
    `CHK(nm, e, v)
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Bounded wait for a start bit, then samples near each bit centre.
  task automatic grab(output logic [7:0] d);
    int n;
    n = 0;
    while (serial_out !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    cyc(8);
    `CHK("start bit", 1'b0, serial_out)
    for (int i = 0; i < 8; i++) begin
      cyc(16);
      d[i] = serial_out;
    end
    cyc(16);
    `CHK("stop bit", 1'b1, serial_out)
  endtask : grab

  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    `CHK("irq", 1'b0, irq)
    `CHK("tx ready", 1'b0, tx_rdy_n)
    `CHK("rx ready", 1'b1, rx_rdy_n)
    rchk(UFHIC_ADDR_MASK, UFHIC_MASK_RESET, "mask");
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h60, "status");
    rchk(UFHIC_ADDR_QUEUE, 8'h01, "ident");
  endtask : t_reset

  // Queues off: shifter plus one holding slot, third write is dropped.
  task automatic t_tx;
    logic [7:0] d;
    int lows;
    lows = 0;
    host.wr(UFHIC_ADDR_HOLDING, 8'hA5);
    host.wr(UFHIC_ADDR_HOLDING, 8'h3C);
    host.wr(UFHIC_ADDR_HOLDING, 8'hC3);
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h00, "status full");
    grab(d);
    `CHK("first char", 8'hA5, d)
    grab(d);
    `CHK("second char", 8'h3C, d)
    repeat (200) begin
      @(negedge clk);
      lows += !serial_out;
    end
    `CHK("dropped char", 0, lows)
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h60, "status idle");
    `CHK("tx ready idle", 1'b0, tx_rdy_n)
  endtask : t_tx

  task automatic t_rx;
    host.wr(UFHIC_ADDR_QUEUE, 8'h41);
    host.wr(UFHIC_ADDR_MASK, 8'h01);
    for (int i = 0; i < 3; i++) host.send(8'h10 + 8'(i), 1'b1);
    `CHK("irq below", 1'b0, irq)
    `CHK("rx ready", 1'b0, rx_rdy_n)
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h61, "ready");
    host.send(8'h13, 1'b1);
    `CHK("irq at level", 1'b1, irq)
    rchk(UFHIC_ADDR_QUEUE, 8'hC4, "ident data");
    rchk(UFHIC_ADDR_HOLDING, 8'h10, "oldest");
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    cyc(700);
    rchk(UFHIC_ADDR_QUEUE, 8'hCC, "ident timeout");
    for (int i = 1; i < 4; i++) rchk(UFHIC_ADDR_HOLDING, 8'h10 + 8'(i), "data");
    cyc(2);
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h60, "drained");
    `CHK("rx ready empty", 1'b1, rx_rdy_n)
  endtask : t_rx

  task automatic t_false;
    host.glitch(4);
    cyc(200);
    `CHK("rx ready false", 1'b1, rx_rdy_n)
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h60, "no char");
  endtask : t_false

  task automatic t_err;
    host.wr(UFHIC_ADDR_MASK, 8'h04);
    host.send(8'h55, 1'b0);
    `CHK("irq line", 1'b1, irq)
    rchk(UFHIC_ADDR_QUEUE, 8'hC6, "ident line");
    rchk(UFHIC_ADDR_LINE_STATUS, 8'hE9, "framing");
    rchk(UFHIC_ADDR_HOLDING, 8'h55, "bad char");
    cyc(2);
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h60, "clean");
    host.wr(UFHIC_ADDR_MASK, 8'h00);
  endtask : t_err

  task automatic t_dma;
    host.wr(UFHIC_ADDR_QUEUE, 8'h09);
    host.send(8'h5A, 1'b1);
    `CHK("rx ready mode1", 1'b0, rx_rdy_n)
    host.wr(UFHIC_ADDR_QUEUE, 8'h0B);
    cyc(2);
    `CHK("rx ready flushed", 1'b1, rx_rdy_n)
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h60, "rx flushed");
    for (int i = 0; i < 17; i++) host.wr(UFHIC_ADDR_HOLDING, 8'(i));
    cyc(2);
    `CHK("tx ready full", 1'b1, tx_rdy_n)
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h00, "tx full");
    host.wr(UFHIC_ADDR_QUEUE, 8'h0D);
    cyc(2);
    `CHK("tx ready empty", 1'b0, tx_rdy_n)
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h20, "shifter kept");
    cyc(200);
    rchk(UFHIC_ADDR_LINE_STATUS, 8'h60, "shifter done");
  endtask : t_dma

  task automatic t_irq;
    host.wr(UFHIC_ADDR_MASK, 8'h02);
    cyc(3);
    `CHK("irq tx empty", 1'b1, irq)
    rchk(UFHIC_ADDR_QUEUE, 8'hC2, "ident tx");
    host.wr(UFHIC_ADDR_MASK, 8'h08);
    modem_event <= 1'b1;
    cyc(3);
    `CHK("irq modem", 1'b1, irq)
    rchk(UFHIC_ADDR_QUEUE, 8'hC0, "ident modem");
    modem_event <= 1'b0;
    cyc(3);
    `CHK("irq modem gone", 1'b0, irq)
    host.wr(UFHIC_ADDR_MASK, 8'h00);
    modem_event <= 1'b1;
    cyc(4);
    `CHK("irq polled", 1'b0, irq)
    modem_event <= 1'b0;
    host.wr(UFHIC_ADDR_QUEUE, 8'hC0);
    rchk(UFHIC_ADDR_QUEUE, 8'h01, "queues off");
  endtask : t_irq

  // Trigger level eight: seven characters stay quiet, the eighth raises the interrupt.
  task automatic t_trig;
    host.wr(UFHIC_ADDR_QUEUE, 8'h83);
    host.wr(UFHIC_ADDR_MASK, 8'h01);
    for (int i = 0; i < 7; i++) host.send(8'(i), 1'b1);
    `CHK("irq seven", 1'b0, irq)
    host.send(8'h07, 1'b1);
    `CHK("irq eight", 1'b1, irq)
    host.wr(UFHIC_ADDR_QUEUE, 8'h03);
    host.wr(UFHIC_ADDR_MASK, 8'h00);
    cyc(2);
    `CHK("irq flushed", 1'b0, irq)
  endtask : t_trig

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    cyc(6);
    reset_n <= 1'b1;
    cyc(1);
    host.init();
    t_reset();
    t_tx();
    t_rx();
    t_false();
    t_err();
    t_dma();
    t_irq();
    t_trig();
    end_of_test();
  end

  // The scenarios need about 4000 cycles; this allows ten times that.
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
